// *** logic/pwrmon_pkg.sv ***
/*
  Constants shared by the power monitor result logic: register pointers, field
  positions, reset values, conversion timing and the scaling shifts.
  Assumes a single 25 MHz core clock and a word-wide register port in front.
*/
// Functional notes
// [R1] Setup bits 5:3 pick shunt conversion time, 140 us up to 8.244 ms.
// [R2] Setup bits 2:0 pick mode: off, triggered or continuous shunt/bus/both.
// [R3] Operating mode resets to continuous shunt and bus measurement.
// [R4] Shunt drop result is a signed 16-bit two's complement value.
// [R5] Shunt drop weight is 2.5 uV per count, 7FFF is 81.9175 mV.
// [R6] With averaging on, the shunt result shows the averaged value.
// [R7] Supply rail result holds latest reading, 1.25 mV per count, full scale 7FFF.
// [R8] Top bit of the supply rail result always reads zero.
// [R9] One power count equals twenty-five current counts.
// [R10] Power result is current result times supply rail result.
// [R11] Current result is shunt drop result times scaling value.
// [R12] Current result is signed 16-bit at offset 04h, averaged when enabled.
// [R13] Scaling value at 05h is writable, 15 bits, bit 15 unused.
// [R14] While scaling value is zero, current and power read zero; here they clear only at the next math step.
// [R15] A setup write halts any conversion and restarts with new settings.
// [R16] Triggered modes run one sequence per setup write; power-down runs none.
// [R17] Host writes to result registers change nothing.
package pwrmon_pkg;

  // Register pointers as seen by the host.
  localparam logic [7:0] ADDR_SETUP   = 8'h00;
  localparam logic [7:0] ADDR_SHUNT   = 8'h01;
  localparam logic [7:0] ADDR_RAIL    = 8'h02;
  localparam logic [7:0] ADDR_POWER   = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_SCALING = 8'h05;

  // Setup register layout and value after reset.
  localparam int          CT_LSB      = 3;
  localparam int          CT_MSB      = 5;
  localparam int          MODE_LSB    = 0;
  localparam int          MODE_MSB    = 2;
  localparam logic [15:0] SETUP_RESET = 16'h4127;
  localparam logic [14:0] SCALE_RESET = 15'h0000;

  // Conversion timing: printed times in ns and derived cycle counts, rounded up.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS [0:7] = '{140000, 204000, 332000, 588000,
                                        1100000, 2116000, 4156000, 8244000};
  localparam int CONV_CYCLES_DEF [0:7] = '{
    (CONV_TIME_NS[0] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[1] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[2] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[3] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[4] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[5] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[6] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    (CONV_TIME_NS[7] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS};
  localparam int TIMER_W = 18;

  // Scaling: current drops this many bits after the multiply; power divides
  // current times rail so that its LSB is 25 current LSBs at 1.25 mV per count.
  localparam int CURRENT_SHIFT = 11;
  localparam int POWER_RATIO   = 25;
  localparam int POWER_DIV     = POWER_RATIO * 800;

  // Sequencer states.
  typedef enum logic [1:0] {PWRMON_IDLE, PWRMON_SHUNT, PWRMON_RAIL, PWRMON_MATH}
    pwrmon_state_t;

endpackage : pwrmon_pkg

// *** logic/pwrmon_scaler.sv ***
/*
  Current and power arithmetic for the power monitor.
  Purely combinational; the caller registers the outputs at the end of a
  measurement sequence.
*/
`timescale 1ns/1ns
module pwrmon_scaler (
  input  wire logic signed [15:0] shuntDrop,
  input  wire logic        [14:0] scalingBits,
  input  wire logic        [15:0] supplyRailLevel,
  output logic signed      [15:0] currentValue,
  output logic             [15:0] powerValue
);

  logic signed [31:0] currentProd;
  logic signed [31:0] currentShift;
  logic        [15:0] currentMag;
  logic        [31:0] powerProd;
  logic        [31:0] powerQuot;

  // Current is shunt drop times scaling, shifted right by CURRENT_SHIFT, saturated to the signed 16-bit range.
  always_comb
  begin
    currentProd  = shuntDrop * $signed({17'h00000, scalingBits}); // see [R11]
    currentShift = currentProd >>> pwrmon_pkg::CURRENT_SHIFT;
    if (currentShift > 32'sh00007fff)
      currentValue = 16'sh7fff;
    else if (currentShift < -32'sh00008000)
      currentValue = -16'sh8000;
    else
      currentValue = currentShift[15:0]; // see [R12] [R14]
  end

  // Power is magnitude of current times rail, scaled so one power count is
  // twenty-five current counts; it is unsigned because power is never negative.
  always_comb
  begin
    currentMag = currentValue[15] ? 16'(-currentValue) : 16'(currentValue);
    powerProd  = {16'h0000, currentMag} * {16'h0000, supplyRailLevel}; // see [R10]
    powerQuot  = powerProd / 32'(pwrmon_pkg::POWER_DIV); // see [R9]
    powerValue = (powerQuot > 32'h0000ffff) ? 16'hffff : powerQuot[15:0];
  end

endmodule : pwrmon_scaler

// *** logic/pwrmon_result_regs.sv ***
/*
  Result registers, setup decode and conversion sequencer of the power monitor.
  Assumes a serial front end that turns host transactions into word reads and
  writes on the register port, and a converter whose samples are synchronous to
  core_clk and hold steady while a phase ends.
*/
`timescale 1ns/1ns
module pwrmon_result_regs #(
  parameter int CONV_CYCLES [0:7] = pwrmon_pkg::CONV_CYCLES_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  input  wire logic [15:0] shuntSample,
  input  wire logic [15:0] railSample,
  output logic             convBusy,
  output logic             convDone
);

  localparam int TW = pwrmon_pkg::TIMER_W;

  logic [14:0]               setupReg;
  logic [14:0]               scalingReg;
  logic signed [15:0]        shuntReg;
  logic [15:0]               railReg;
  logic signed [15:0]        currentReg;
  logic [15:0]               powerReg;
  logic [TW-1:0]             timerReg;
  pwrmon_pkg::pwrmon_state_t stateReg;
  logic                      setupWr;
  logic [2:0]                modeSel;
  logic [2:0]                shuntConvTime;
  logic [2:0]                wrModeSel;
  logic [2:0]                wrConvTime;
  logic signed [15:0]        currentNext;
  logic [15:0]               powerNext;

  // Mode decode helpers, shared by the sequencer and the checks.
  function automatic logic modeOff(input logic [2:0] m);
    modeOff = (m[1:0] == 2'h0); // see [R2]
  endfunction : modeOff

  function automatic logic modeShunt(input logic [2:0] m);
    modeShunt = m[0];
  endfunction : modeShunt

  function automatic logic modeRail(input logic [2:0] m);
    modeRail = m[1];
  endfunction : modeRail

  function automatic logic modeCont(input logic [2:0] m);
    modeCont = m[2];
  endfunction : modeCont

  // Conversion time lookup: the timer counts down from one less than the count.
  function automatic logic [TW-1:0] loadCount(input logic [2:0] ct);
    loadCount = TW'(CONV_CYCLES[ct] - 1); // see [R1]
  endfunction : loadCount

  // Decoded fields of the live setup register and of the setup write data.
  assign modeSel       = setupReg[pwrmon_pkg::MODE_MSB:pwrmon_pkg::MODE_LSB];
  assign shuntConvTime = setupReg[pwrmon_pkg::CT_MSB:pwrmon_pkg::CT_LSB];
  assign wrModeSel     = regWrData[pwrmon_pkg::MODE_MSB:pwrmon_pkg::MODE_LSB];
  assign wrConvTime    = regWrData[pwrmon_pkg::CT_MSB:pwrmon_pkg::CT_LSB];
  assign setupWr       = regWrEn && (regAddr == pwrmon_pkg::ADDR_SETUP);
  assign convBusy      = (stateReg != pwrmon_pkg::PWRMON_IDLE);

  // Setup register; bit 15 is not stored and reads back zero.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      setupReg <= pwrmon_pkg::SETUP_RESET[14:0]; // see [R3]
    else if (setupWr)
      setupReg <= regWrData[14:0];
  end

  // Scaling register; only bits 14:0 are kept so bit 15 always reads zero.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      scalingReg <= pwrmon_pkg::SCALE_RESET;
    else if (regWrEn && (regAddr == pwrmon_pkg::ADDR_SCALING))
      scalingReg <= regWrData[14:0]; // see [R13]
  end

  // Measurement sequencer. A setup write wins over any phase in flight, so a
  // half-finished sample taken under old settings is never published.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateReg <= pwrmon_pkg::PWRMON_SHUNT;
      timerReg <= TW'(CONV_CYCLES[pwrmon_pkg::SETUP_RESET[pwrmon_pkg::CT_MSB:
                                                  pwrmon_pkg::CT_LSB]] - 1);
    end
    else if (setupWr)
    begin
      // New settings take effect from the cycle after the write.
      if (modeOff(wrModeSel))
        stateReg <= pwrmon_pkg::PWRMON_IDLE; // see [R16]
      else if (modeShunt(wrModeSel))
        stateReg <= pwrmon_pkg::PWRMON_SHUNT; // see [R15]
      else
        stateReg <= pwrmon_pkg::PWRMON_RAIL;
      timerReg <= loadCount(wrConvTime); // see [R15]
    end
    else
    begin
      unique case (stateReg)
        pwrmon_pkg::PWRMON_IDLE:
        begin
          timerReg <= timerReg;
        end
        pwrmon_pkg::PWRMON_SHUNT:
        begin
          if (timerReg != '0)
            timerReg <= timerReg - 1'b1;
          else if (modeRail(modeSel))
          begin
            stateReg <= pwrmon_pkg::PWRMON_RAIL;
            timerReg <= loadCount(shuntConvTime);
          end
          else
            stateReg <= pwrmon_pkg::PWRMON_MATH;
        end
        pwrmon_pkg::PWRMON_RAIL:
        begin
          if (timerReg != '0)
            timerReg <= timerReg - 1'b1;
          else
            stateReg <= pwrmon_pkg::PWRMON_MATH;
        end
        pwrmon_pkg::PWRMON_MATH:
        begin
          // Continuous modes loop; triggered modes stop and hold results.
          timerReg <= loadCount(shuntConvTime);
          if (!modeCont(modeSel))
            stateReg <= pwrmon_pkg::PWRMON_IDLE; // see [R16]
          else if (modeShunt(modeSel))
            stateReg <= pwrmon_pkg::PWRMON_SHUNT;
          else
            stateReg <= pwrmon_pkg::PWRMON_RAIL;
        end
      endcase
    end
  end

  // Shunt capture at the end of its phase. Averaging happens in the converter,
  // so whatever value it presents is what the register shows.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      shuntReg <= '0;
    else if (!setupWr && (stateReg == pwrmon_pkg::PWRMON_SHUNT) && (timerReg == '0))
      shuntReg <= shuntSample; // see [R4] [R5] [R6]
  end

  // Rail capture; the sign position is forced low since the rail is never negative.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      railReg <= '0;
    else if (!setupWr && (stateReg == pwrmon_pkg::PWRMON_RAIL) && (timerReg == '0))
      railReg <= {1'b0, railSample[14:0]}; // see [R7] [R8]
  end

  // Arithmetic on the captured values and the current scaling value.
  pwrmon_scaler uScaler (
    .shuntDrop       (shuntReg),
    .scalingBits     (scalingReg),
    .supplyRailLevel (railReg),
    .currentValue    (currentNext),
    .powerValue      (powerNext)
  );

  // Derived results change only in the math step; host writes never reach them.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      currentReg <= '0;
      powerReg   <= '0;
    end
    else if (!setupWr && (stateReg == pwrmon_pkg::PWRMON_MATH))
    begin
      currentReg <= currentNext; // see [R11] [R17]
      powerReg   <= powerNext; // see [R10]
    end
  end

  // One-cycle completion pulse, set on the same edge that publishes the results.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      convDone <= 1'b0;
    else
      convDone <= !setupWr && (stateReg == pwrmon_pkg::PWRMON_MATH);
  end

  // Read port: data appears the cycle after the strobe; unmapped pointers read zero.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdData <= '0;
    else if (regRdEn)
    begin
      unique case (regAddr)
        pwrmon_pkg::ADDR_SETUP:   regRdData <= {1'b0, setupReg};
        pwrmon_pkg::ADDR_SHUNT:   regRdData <= shuntReg;
        pwrmon_pkg::ADDR_RAIL:    regRdData <= {1'b0, railReg[14:0]}; // see [R8]
        pwrmon_pkg::ADDR_POWER:   regRdData <= powerReg;
        pwrmon_pkg::ADDR_CURRENT: regRdData <= currentReg; // see [R12]
        pwrmon_pkg::ADDR_SCALING: regRdData <= {1'b0, scalingReg}; // see [R13]
        default:                  regRdData <= '0;
      endcase
    end
  end

  // Checks on the published behaviour. They share one clock and one reset, so
  // the defaults below carry both and each property stays short.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  rail_top_zero_a: assert property ( // see [R8]
    (regRdEn && (regAddr == pwrmon_pkg::ADDR_RAIL)) |=> (regRdData[15] == 1'b0))
    else $error("Supply rail read returned a set top bit.");

  cal_zero_results_a: assert property ( // see [R14]
    ((stateReg == pwrmon_pkg::PWRMON_MATH) && !setupWr && (scalingReg == '0))
      |=> ((currentReg == '0) && (powerReg == '0)))
    else $error("Results nonzero while scaling value is zero.");

  results_hold_a: assert property ( // see [R17]
    (stateReg != pwrmon_pkg::PWRMON_MATH) |=> ($stable(currentReg) && $stable(powerReg)))
    else $error("Derived results changed outside the math step.");

  setup_restart_a: assert property ( // see [R15]
    (setupWr && !modeOff(wrModeSel))
      |=> (convBusy && (timerReg == loadCount($past(wrConvTime)))))
    else $error("Setup write did not restart conversion with new timing.");

  power_down_a: assert property ( // see [R2]
    (setupWr && modeOff(wrModeSel)) |=> (!convBusy [*2]))
    else $error("Conversion running in power-down.");

  trigger_once_a: assert property ( // see [R16]
    ((stateReg == pwrmon_pkg::PWRMON_MATH) && !setupWr && !modeCont(modeSel))
      |=> (stateReg == pwrmon_pkg::PWRMON_IDLE) ##1 (!convBusy || $past(setupWr)))
    else $error("Triggered mode did not stop after one sequence.");

  current_sign_a: assert property ( // see [R11]
    ((stateReg == pwrmon_pkg::PWRMON_MATH) && !setupWr && !shuntReg[15])
      |=> !currentReg[15])
    else $error("Positive shunt drop gave a negative current.");

  rail_zero_power_a: assert property ( // see [R10]
    ((stateReg == pwrmon_pkg::PWRMON_MATH) && !setupWr && (railReg == '0))
      |=> ((powerReg == '0) && convDone))
    else $error("Power nonzero with zero supply rail.");

  // Each phase publishes the sample it ended on, the rail with its top bit cleared;
  // a setup write in that cycle discards the sample instead.
  shunt_capture_a: assert property ( // see [R4]
    ((stateReg == pwrmon_pkg::PWRMON_SHUNT) && (timerReg == '0) && !setupWr)
      |=> (shuntReg == $past(shuntSample)))
    else $error("Shunt drop result did not take the ending sample.");

  rail_capture_a: assert property ( // see [R7]
    ((stateReg == pwrmon_pkg::PWRMON_RAIL) && (timerReg == '0) && !setupWr)
      |=> (railReg == {1'b0, $past(railSample[14:0])}))
    else $error("Supply rail result did not take the ending sample.");

  // Results move only at the end of their own phase, whatever the host writes.
  shunt_hold_a: assert property ( // see [R17]
    !((stateReg == pwrmon_pkg::PWRMON_SHUNT) && (timerReg == '0)) |=> $stable(shuntReg))
    else $error("Shunt drop result changed outside its capture cycle.");

  scaling_write_a: assert property ( // see [R13]
    (regWrEn && (regAddr == pwrmon_pkg::ADDR_SCALING))
      |=> (scalingReg == $past(regWrData[14:0])))
    else $error("Scaling value write was not stored.");

  setup_write_a: assert property ( // see [R1]
    setupWr |=> (shuntConvTime == $past(wrConvTime)))
    else $error("Conversion time field did not follow the setup write.");

  // A finished triggered sequence stays parked until the host writes the setup register again.
  idle_parked_a: assert property ( // see [R16]
    ((stateReg == pwrmon_pkg::PWRMON_IDLE) && !setupWr) |=> !convBusy)
    else $error("Sequencer left idle without a setup write.");

  done_pulse_a: assert property ( // see [R16]
    convDone |=> !convDone)
    else $error("Completion pulse lasted more than one cycle.");

  // Rail-only modes skip the shunt phase, so the last shunt value is reused.
  rail_only_a: assert property ( // see [R2]
    (setupWr && !modeOff(wrModeSel) && !modeShunt(wrModeSel))
      |=> (stateReg == pwrmon_pkg::PWRMON_RAIL))
    else $error("Rail-only mode did not start with the rail phase.");

  shunt_first_a: assert property ( // see [R2]
    (setupWr && modeShunt(wrModeSel))
      |=> (stateReg == pwrmon_pkg::PWRMON_SHUNT))
    else $error("Shunt mode did not start with the shunt phase.");

endmodule : pwrmon_result_regs

// *** test/pwrmon_conv_model.sv ***
/*
  Behavioural converter that faces the power monitor sample inputs.
  Assumes the bench sets the analog levels and that samples are only
  trusted while the sequencer is busy.
*/
`timescale 1ns/1ns
module pwrmon_conv_model (
  input  wire logic        convBusy,
  input  wire logic [15:0] shuntLevel,
  input  wire logic [15:0] railLevel,
  output logic      [15:0] shuntSample,
  output logic      [15:0] railSample
);
  // Outside a conversion the samples show the inverted level, so a design that
  // captures while idle reads a wrong value instead of a lucky right one.
  assign shuntSample = convBusy ? shuntLevel : ~shuntLevel;
  assign railSample  = convBusy ? railLevel : ~railLevel;
endmodule : pwrmon_conv_model

// *** test/tb_top.sv ***
/*
  Self-checking bench for the power monitor result registers.
  Assumes the word-wide register port and shortened conversion counts.
*/
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin nCompared++; if ((got) !== (exp)) begin nErrors++; \
  $display("Error at %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  typedef struct packed {logic [2:0] ct; logic [15:0] scl; logic [15:0] sh; logic [15:0] rl;
    logic [15:0] cur; logic [15:0] pw;} pwrmon_row_t;
  localparam int CYC [0:7] = '{4, 5, 6, 7, 8, 9, 10, 11};
  logic        core_clk, arst_n, regWrEn, regRdEn, convBusy, convDone;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, shuntSample, railSample, shuntLevel, railLevel;
  int          nErrors, nCompared, k;
  pwrmon_row_t rows [0:4];

  pwrmon_result_regs #(.CONV_CYCLES(CYC)) pwrmon_result_regs_inst (.core_clk(core_clk),
    .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .shuntSample(shuntSample),
    .railSample(railSample), .convBusy(convBusy), .convDone(convDone));
  pwrmon_conv_model pwrmon_conv_model_inst (.convBusy(convBusy), .shuntLevel(shuntLevel),
    .railLevel(railLevel), .shuntSample(shuntSample), .railSample(railSample));

  // Free-running 25 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // One word write; the strobe spans exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask : wr

  // One word read, checked once the data has settled after the read edge.
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    `CHK(regRdData, exp)
  endtask : rdChk

  // Bounded wait for the completion pulse, counting falling edges.
  task automatic waitDone(output int n);
    n = 0;
    while (convDone !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) nErrors++;
  endtask : waitDone

  // Prints the counts and the verdict, then ends the run.
  task automatic finishTest();
    $display("Compared %0d, errors %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finishTest

  // Watchdog sized well above the longest expected run.
  initial
  begin
    #(40 * 20000);
    nErrors++;
    finishTest();
  end

  // Reset, table of conversions, then the awkward cases.
  initial
  begin
    {arst_n, regWrEn, regRdEn, regAddr, regWrData} = '0;
    shuntLevel = 16'h1000;
    railLevel = 16'h0100;
    // Columns: time code, scaling, shunt, rail, then expected current and power.
    rows[0] = '{3'd0, 16'h0800, 16'h1234, 16'hffff, 16'h1234, 16'h1dd2};
    rows[1] = '{3'd7, 16'h7fff, 16'h7fff, 16'h2000, 16'h7fff, 16'h346d};
    rows[2] = '{3'd3, 16'h1000, 16'h8300, 16'h0100, 16'h8000, 16'h01a3};
    rows[3] = '{3'd5, 16'hffff, 16'hfffe, 16'h0001, 16'hffe0, 16'h0000};
    rows[4] = '{3'd1, 16'h0400, 16'h8000, 16'h8000, 16'hc000, 16'h0000};
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    rdChk(8'h00, 16'h4127);
    rdChk(8'h05, 16'h0000);
    waitDone(k);
    `CHK(k <= 2 * CYC[4] + 2, 1'b1)
    rdChk(8'h01, 16'h1000);
    rdChk(8'h04, 16'h0000);
    rdChk(8'h03, 16'h0000);
    wr(8'h01, 16'h5555);
    rdChk(8'h01, 16'h1000);
    rdChk(8'h07, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      shuntLevel = rows[i].sh;
      railLevel = rows[i].rl;
      wr(8'h05, rows[i].scl);
      wr(8'h00, {10'h000, rows[i].ct, 3'h3});
      waitDone(k);
      `CHK(k >= 2 * CYC[rows[i].ct] && k <= 2 * CYC[rows[i].ct] + 2, 1'b1)
      rdChk(8'h01, rows[i].sh);
      rdChk(8'h02, {1'b0, rows[i].rl[14:0]});
      rdChk(8'h04, rows[i].cur);
      rdChk(8'h03, rows[i].pw);
      rdChk(8'h05, rows[i].scl & 16'h7fff);
      rdChk(8'h00, {10'h000, rows[i].ct, 3'h3});
    end
    shuntLevel = 16'h0777;
    repeat (30) @(negedge core_clk);
    `CHK(convBusy, 1'b0)
    rdChk(8'h01, rows[4].sh);
    wr(8'h00, 16'h0013);
    repeat (5) @(negedge core_clk);
    wr(8'h00, 16'h0003);
    waitDone(k);
    `CHK(k >= 2 * CYC[0] && k <= 2 * CYC[0] + 2, 1'b1)
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h00, 16'(m));
      repeat (2) @(negedge core_clk);
      `CHK(convBusy, logic'(m[1:0] != 2'b00))
      if (m == 1) waitDone(k);
      if (m == 1) rdChk(8'h01, 16'h0777);
    end
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(convBusy, 1'b1)
    arst_n = 1'b1;
    rdChk(8'h00, 16'h4127);
    rdChk(8'h05, 16'h0000);
    rdChk(8'h04, 16'h0000);
    finishTest();
  end
endmodule : tb_top
